// ===== core/svr_card_port.sv
// Card end: backplane slave answering byte reads of the sixteen-byte image.
// Assumes bus inputs synchronous to ref_clk and a host that holds strobes until answered.
//
// Functional notes
// R1: Answer only address modifier 29h.
// R2: Decode short 16-bit addresses only.
// R3: Expansion controller maps 1Eh..18h to 29h.
// R4: Host never issues reserved modifier 1Fh.
// R5: Host reads exactly sixteen bytes per image.
// R6: Byte cycles only; word cycles fail.
// R7: Image starts at switch-selected base.
// R8: Image holds position, rate, raw word.
// R9: Raw serial bits passed through untouched.
// R10: Absent transducer reads all ones.
// R11: One serial word per host read.
// R12: Green indicator lit while operational.
// R13: Red indicator lit on init failure.
// R14: Memory error reported, host write clears.
// R15: Host trusts data only on success.
// R16: Command at base+80h, parameters at +82h.
// R17: Image bytes consecutive, fixed order.
`timescale 1ns/1ps
`default_nettype none
module svr_card_port
	import svr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	svr_bus_if.card bus,
	input wire logic [4:0] base_sw,
	input wire logic [31:0] pos_value,
	input wire logic [31:0] rate_value,
	input wire logic [31:0] ssi_word,
	input wire logic ssi_word_vld,
	output logic ssi_frame_req,
	input wire logic nv_err_evt,
	input wire logic init_done,
	input wire logic init_fail,
	output logic run_led,
	output logic fault_led,
	output logic [15:0] cmd_word,
	output logic par_wr_stb,
	output logic [3:0] par_wr_idx,
	output logic [7:0] par_wr_data
);
	typedef enum logic [1:0] {
		SVR_ST_IDLE = 2'h0,
		SVR_ST_ACK = 2'h1,
		SVR_ST_ERR = 2'h2
	} svr_card_st_e;

	// Picks byte k of the image, most significant byte at the lowest offset
	function automatic logic [7:0] img_byte(input logic [127:0] img, input logic [3:0] k);
		img_byte = img[8'd127 - {k, 3'h0} -: 8];
	endfunction

	svr_card_st_e st_q, st_d;
	logic [7:0] rd_q, rd_d;
	logic [127:0] snap_q, snap_d;
	logic [31:0] raw_q, raw_d;
	logic wait_q, wait_d;
	logic frame_q, frame_d;
	logic nv_q, nv_d;
	logic done_q, done_d;
	logic fail_q, fail_d;
	logic [15:0] cmd_q, cmd_d;
	logic pstb_q, pstb_d;
	logic [3:0] pidx_q, pidx_d;
	logic [7:0] pdat_q, pdat_d;
	logic sel;
	logic is_word;
	logic any_ds;
	logic [10:0] ofs;
	logic [15:0] stat;
	logic [127:0] live;
	logic [10:0] pofs;

	// Selection: modifier, upper five address bits and a data strobe
	assign any_ds = ~bus.ds0_n | ~bus.ds1_n;
	assign is_word = ~bus.ds0_n & ~bus.ds1_n; // R6
	assign ofs = bus.a[10:0];
	assign sel = ~bus.as_n & any_ds
		& (bus.am == SVR_AM_SHORT_NP) // R1
		& (bus.a[15:11] == base_sw); // R2 R7
	assign pofs = ofs - SVR_OFS_PAR_FIRST;

	// Status word and live image in fixed byte order
	always_comb begin
		stat = SVR_RSVD_WORD;
		stat[SVR_STAT_NV_ERR_BIT] = nv_q; // R14
		stat[SVR_STAT_RUN_BIT] = run_led;
		stat[SVR_STAT_FAULT_BIT] = fail_q;
		live = {pos_value, rate_value, raw_q, stat, SVR_RSVD_WORD}; // R8 R9 R17
	end

	// Bus cycle state, read data and snapshot
	always_comb begin
		st_d = st_q;
		rd_d = rd_q;
		snap_d = snap_q;
		case (st_q)
			SVR_ST_IDLE: begin
				if (sel) begin
					if (is_word) begin
						st_d = SVR_ST_ERR; // R6
					end else begin
						st_d = SVR_ST_ACK;
						rd_d = 8'h00;
						if (bus.write_n && ofs <= SVR_OFS_IMG_LAST) begin
							// Offset 0 freezes the image so all sixteen bytes agree
							if (ofs == 11'h000) begin
								snap_d = live; // R17
								rd_d = img_byte(live, 4'h0);
							end else begin
								rd_d = img_byte(snap_q, ofs[3:0]); // R17
							end
						end
					end
				end
			end
			SVR_ST_ACK, SVR_ST_ERR: begin
				// Hold the answer until the host lets go of its strobes
				if (!any_ds || bus.as_n) begin
					st_d = SVR_ST_IDLE;
				end
			end
			default: begin
				st_d = SVR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= SVR_ST_IDLE;
			rd_q <= 8'h00;
			snap_q <= '0;
		end else begin
			st_q <= st_d;
			rd_q <= rd_d;
			snap_q <= snap_d;
		end
	end

	assign bus.rd = rd_q;
	assign bus.dtack_n = (st_q != SVR_ST_ACK);
	assign bus.berr_n = (st_q != SVR_ST_ERR);

	// Serial receiver: one frame per image read, first word only
	always_comb begin
		raw_d = raw_q;
		wait_d = wait_q;
		frame_d = 1'b0;
		if (st_q == SVR_ST_IDLE && sel && !is_word && bus.write_n && ofs == 11'h000) begin
			frame_d = 1'b1; // R11
			wait_d = 1'b1;
		end else if (wait_q && ssi_word_vld) begin
			raw_d = ssi_word; // R9 R10
			wait_d = 1'b0; // R11
		end
	end

	// Raw word idles high, so nothing attached still reads as all ones
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			raw_q <= SVR_RAW_ABSENT; // R10
			wait_q <= 1'b0;
			frame_q <= 1'b0;
		end else begin
			raw_q <= raw_d;
			wait_q <= wait_d;
			frame_q <= frame_d;
		end
	end

	assign ssi_frame_req = frame_q;

	// Host writes: command bytes, parameter bytes, memory error clear
	always_comb begin
		cmd_d = cmd_q;
		pstb_d = 1'b0;
		pidx_d = pidx_q;
		pdat_d = pdat_q;
		nv_d = nv_q;
		if (st_q == SVR_ST_IDLE && sel && !is_word && !bus.write_n) begin
			if (ofs == SVR_OFS_CMD_HI) begin
				cmd_d[15:8] = bus.wd; // R16
			end else if (ofs == SVR_OFS_CMD_LO) begin
				cmd_d[7:0] = bus.wd; // R16
				if (bus.wd[SVR_CMD_CLR_NV_BIT]) begin
					nv_d = 1'b0; // R14
				end
			end else if (ofs >= SVR_OFS_PAR_FIRST && ofs <= SVR_OFS_PAR_LAST) begin
				pstb_d = 1'b1; // R16
				pidx_d = pofs[3:0];
				pdat_d = bus.wd;
			end
		end
		// A new error in the clearing cycle is kept
		if (nv_err_evt) begin
			nv_d = 1'b1; // R14
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmd_q <= SVR_CMD_RESET;
			pstb_q <= 1'b0;
			pidx_q <= 4'h0;
			pdat_q <= 8'h00;
			nv_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			pstb_q <= pstb_d;
			pidx_q <= pidx_d;
			pdat_q <= pdat_d;
			nv_q <= nv_d;
		end
	end

	assign cmd_word = cmd_q;
	assign par_wr_stb = pstb_q;
	assign par_wr_idx = pidx_q;
	assign par_wr_data = pdat_q;

	// Start-up outcome; a failure stays latched until the next reset
	always_comb begin
		done_d = done_q | init_done;
		fail_d = fail_q | init_fail;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			done_q <= done_d;
			fail_q <= fail_d;
		end
	end

	assign run_led = done_q & ~fail_q; // R12
	assign fault_led = fail_q; // R13
endmodule
`default_nettype wire

// ===== core/svr_pkg.sv
// Shared constants for the serial-transducer card read port and its host.
// Assumes one 100 MHz clock and a synchronous, active-high reset on both ends.
package svr_pkg;
	// Bus decode
	localparam logic [5:0] SVR_AM_SHORT_NP = 6'h29;
	localparam logic [5:0] SVR_AM_RESERVED = 6'h1F;
	localparam logic [5:0] SVR_AM_EXP_LO = 6'h18;
	localparam logic [5:0] SVR_AM_EXP_HI = 6'h1E;
	localparam int SVR_ADDR_W = 16;
	localparam int SVR_SW_W = 5;
	localparam int SVR_OFS_W = 11;
	// Window layout
	localparam int SVR_IMG_BYTES = 16;
	localparam logic [10:0] SVR_OFS_IMG_LAST = 11'h00F;
	localparam logic [10:0] SVR_OFS_CMD_HI = 11'h080;
	localparam logic [10:0] SVR_OFS_CMD_LO = 11'h081;
	localparam logic [10:0] SVR_OFS_PAR_FIRST = 11'h082;
	localparam logic [10:0] SVR_OFS_PAR_LAST = 11'h08F;
	// Read image: position 0..3, rate 4..7, raw word 8..11, status 12..13, 14..15 zero
	localparam logic [31:0] SVR_RAW_ABSENT = 32'hFFFFFFFF;
	localparam logic [15:0] SVR_RSVD_WORD = 16'h0000;
	localparam int SVR_STAT_NV_ERR_BIT = 0;
	localparam int SVR_STAT_RUN_BIT = 1;
	localparam int SVR_STAT_FAULT_BIT = 2;
	localparam int SVR_CMD_CLR_NV_BIT = 0;
	localparam logic [15:0] SVR_CMD_RESET = 16'h0000;
	// Host timing
	localparam int SVR_CLK_NS = 10;
	localparam int SVR_HOST_TMO_NS = 5000;
	localparam int SVR_HOST_TMO_CYC = SVR_HOST_TMO_NS / SVR_CLK_NS;
endpackage

// ===== core/svr_bus_if.sv
// Backplane signals between the card read port and the host reader.
// Both ends drive separate nets, so no wire resolution is needed here.
`timescale 1ns/1ps
`default_nettype none
interface svr_bus_if;
	logic [5:0] am;
	logic [15:0] a;
	logic as_n;
	logic ds0_n;
	logic ds1_n;
	logic write_n;
	logic [7:0] wd;
	logic [7:0] rd;
	logic dtack_n;
	logic berr_n;
	modport card (input am, a, as_n, ds0_n, ds1_n, write_n, wd, output rd, dtack_n, berr_n);
	modport host (output am, a, as_n, ds0_n, ds1_n, write_n, wd, input rd, dtack_n, berr_n);
endinterface
`default_nettype wire

// ===== core/svr_host_reader.sv
// Host end: reads the sixteen-byte image byte by byte and writes single bytes.
// Assumes the card answers on dtack_n or berr_n; a silent card ends in a timeout.
`timescale 1ns/1ps
`default_nettype none
module svr_host_reader
	import svr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	svr_bus_if.host bus,
	input wire logic rd_start,
	input wire logic wr_start,
	input wire logic word_mode,
	input wire logic [5:0] am_req,
	input wire logic [15:0] base_addr,
	input wire logic [10:0] wr_ofs,
	input wire logic [7:0] wr_data,
	output logic busy,
	output logic done,
	output logic xfer_ok,
	output logic am_fault,
	output logic [127:0] img_data
);
	typedef enum logic [1:0] {
		SVR_H_IDLE = 2'h0,
		SVR_H_STROBE = 2'h1,
		SVR_H_RELEASE = 2'h3,
		SVR_H_DONE = 2'h2
	} svr_host_st_e;

	svr_host_st_e st_q, st_d;
	logic [5:0] am_q, am_d;
	logic [15:0] a_q, a_d;
	logic wr_q, wr_d;
	logic word_q, word_d;
	logic [7:0] wd_q, wd_d;
	logic [3:0] idx_q, idx_d;
	logic [15:0] tmo_q, tmo_d;
	logic fail_q, fail_d;
	logic ok_q, ok_d;
	logic amf_q, amf_d;
	logic [127:0] img_q, img_d;

	always_comb begin
		st_d = st_q;
		am_d = am_q;
		a_d = a_q;
		wr_d = wr_q;
		word_d = word_q;
		wd_d = wd_q;
		idx_d = idx_q;
		tmo_d = tmo_q;
		fail_d = fail_q;
		ok_d = ok_q;
		amf_d = amf_q;
		img_d = img_q;
		case (st_q)
			SVR_H_IDLE: begin
				if (rd_start || wr_start) begin
					ok_d = 1'b0;
					fail_d = 1'b0;
					idx_d = 4'h0;
					tmo_d = 16'h0000;
					wr_d = wr_start & ~rd_start;
					word_d = word_mode;
					wd_d = wr_data;
					a_d = rd_start ? base_addr : base_addr + {5'h00, wr_ofs};
					// Expansion rack codes reach the card as 29h; 1Fh never goes out
					amf_d = (am_req == SVR_AM_RESERVED); // R4
					if (am_req >= SVR_AM_EXP_LO && am_req <= SVR_AM_EXP_HI) begin
						am_d = SVR_AM_SHORT_NP; // R3
					end else begin
						am_d = am_req;
					end
					st_d = (am_req == SVR_AM_RESERVED) ? SVR_H_DONE : SVR_H_STROBE;
				end
			end
			SVR_H_STROBE: begin
				tmo_d = tmo_q + 16'h0001;
				if (!bus.dtack_n) begin
					if (!wr_q) begin
						img_d[8'd127 - {idx_q, 3'h0} -: 8] = bus.rd;
					end
					st_d = SVR_H_RELEASE;
				end else if (!bus.berr_n || tmo_q == 16'(SVR_HOST_TMO_CYC - 1)) begin
					fail_d = 1'b1;
					st_d = SVR_H_RELEASE;
				end
			end
			SVR_H_RELEASE: begin
				if (bus.dtack_n && bus.berr_n) begin
					if (fail_q || wr_q || idx_q == 4'(SVR_IMG_BYTES - 1)) begin // R5
						st_d = SVR_H_DONE;
					end else begin
						idx_d = idx_q + 4'h1;
						a_d = a_q + 16'h0001;
						tmo_d = 16'h0000;
						st_d = SVR_H_STROBE;
					end
				end
			end
			SVR_H_DONE: begin
				ok_d = ~fail_q & ~amf_q; // R15
				st_d = SVR_H_IDLE;
			end
			default: begin
				st_d = SVR_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= SVR_H_IDLE;
			am_q <= 6'h00;
			a_q <= 16'h0000;
			wr_q <= 1'b0;
			word_q <= 1'b0;
			wd_q <= 8'h00;
			idx_q <= 4'h0;
			tmo_q <= 16'h0000;
			fail_q <= 1'b0;
			ok_q <= 1'b0;
			amf_q <= 1'b0;
			img_q <= '0;
		end else begin
			st_q <= st_d;
			am_q <= am_d;
			a_q <= a_d;
			wr_q <= wr_d;
			word_q <= word_d;
			wd_q <= wd_d;
			idx_q <= idx_d;
			tmo_q <= tmo_d;
			fail_q <= fail_d;
			ok_q <= ok_d;
			amf_q <= amf_d;
			img_q <= img_d;
		end
	end

	// Strobes low only in the strobe state; a word request lowers both lanes
	assign bus.am = am_q;
	assign bus.a = a_q;
	assign bus.as_n = (st_q != SVR_H_STROBE);
	assign bus.ds0_n = (st_q != SVR_H_STROBE);
	assign bus.ds1_n = (st_q != SVR_H_STROBE) | ~word_q; // R6
	assign bus.write_n = ~wr_q;
	assign bus.wd = wd_q;
	assign busy = (st_q != SVR_H_IDLE);
	assign done = (st_q == SVR_H_DONE);
	assign xfer_ok = ok_q;
	assign am_fault = amf_q;
	assign img_data = img_q;
endmodule
`default_nettype wire

// ===== sim/svr_bus_sva.sv
// Checker for the backplane handshake between card port and host reader.
// Assumes it sees the interface nets directly, sampled on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module svr_bus_sva
	import svr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [5:0] am,
	input wire logic [15:0] a,
	input wire logic as_n,
	input wire logic ds0_n,
	input wire logic ds1_n,
	input wire logic write_n,
	input wire logic [7:0] wd,
	input wire logic [7:0] rd,
	input wire logic dtack_n,
	input wire logic berr_n
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// Answers only ever follow the short non-privileged modifier
	a_am_gate: assert property ($fell(dtack_n) |-> $past(am) == SVR_AM_SHORT_NP)
		else $error("acknowledge for a foreign modifier");
	a_berr_am: assert property ($fell(berr_n) |-> $past(am) == SVR_AM_SHORT_NP)
		else $error("bus error for a foreign modifier");
	// Byte cycles acknowledged, word cycles refused with a bus error
	a_byte_ack: assert property ($fell(dtack_n) |-> $past(ds0_n ^ ds1_n) && $past(!as_n))
		else $error("acknowledge without a byte strobe");
	a_word_berr: assert property ($fell(berr_n) |-> $past(!ds0_n && !ds1_n))
		else $error("bus error without a word strobe");
	a_ack_excl: assert property (!(!dtack_n && !berr_n))
		else $error("acknowledge and bus error together");
	// The acknowledge stands while the host still strobes, and ends only after release
	a_ack_hold: assert property ((!dtack_n && !as_n && !(ds0_n && ds1_n)) |=> !dtack_n)
		else $error("acknowledge dropped under live strobes");
	a_ack_release: assert property ($rose(dtack_n) |-> $past(as_n || (ds0_n && ds1_n)))
		else $error("acknowledge ended before strobes released");
	a_idle_gap: assert property ($rose(dtack_n) |=> dtack_n && berr_n)
		else $error("no idle cycle after a cycle");
	// Offsets above the image read as zero
	a_zero_high: assert property (($fell(dtack_n) && $past(write_n)
		&& ($past(a) & 16'h07F0) != 16'h0000) |-> rd == 8'h00)
		else $error("nonzero byte above the image");

	c_byte_read: cover property ($fell(dtack_n) && write_n);
	c_byte_write: cover property ($fell(dtack_n) && !write_n);
	c_word_berr: cover property ($fell(berr_n));
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Bench joining card port and host reader over the backplane interface.
// Assumes the host addresses base_addr plus offset; serial far side is a one-line responder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
	$display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_top
	import svr_pkg::*;
;
	typedef struct packed {
		logic [5:0] am;
		logic wm;
		logic [15:0] base;
		logic ok;
		logic amf;
	} svr_row_s;
	localparam logic [31:0] POS = 32'h1234ABCD;
	localparam logic [31:0] RATE = 32'hFFFF8001;
	localparam logic [31:0] SSIW = 32'h80000003; // Edge bits stand in for transducer error flags
	logic ref_clk = 1'h0, srst = 1'h1, ssi_word_vld = 1'h0, nv_err_evt = 1'h0;
	logic init_done = 1'h0, init_fail = 1'h0, rd_start = 1'h0, wr_start = 1'h0, word_mode = 1'h0;
	logic [5:0] am_req = 6'h29;
	logic [15:0] base_addr = 16'h1000;
	logic [10:0] wr_ofs = 11'h000;
	logic [7:0] wr_data = 8'h00, par_data_seen = 8'h00, par_wr_data;
	logic [3:0] par_idx_seen = 4'h0, par_wr_idx;
	logic [31:0] raw_exp = SVR_RAW_ABSENT;
	logic ssi_frame_req, run_led, fault_led, par_wr_stb, busy, done, xfer_ok, am_fault;
	logic [15:0] cmd_word;
	logic [127:0] img_data;
	int mismatches = 0, check_count = 0, cycles = 0;
	int frames = 0, acks = 0;
	logic ack_prev = 1'h1;
	logic [4:0] base_sw = 5'h02;
	svr_row_s rows [13] = '{
		'{6'h29, 1'h0, 16'h1000, 1'h1, 1'h0}, '{6'h1E, 1'h0, 16'h1000, 1'h1, 1'h0},
		'{6'h1D, 1'h0, 16'h1000, 1'h1, 1'h0}, '{6'h1C, 1'h0, 16'h1000, 1'h1, 1'h0},
		'{6'h1B, 1'h0, 16'h1000, 1'h1, 1'h0}, '{6'h1A, 1'h0, 16'h1000, 1'h1, 1'h0},
		'{6'h19, 1'h0, 16'h1000, 1'h1, 1'h0}, '{6'h18, 1'h0, 16'h1000, 1'h1, 1'h0},
		'{6'h1F, 1'h0, 16'h1000, 1'h0, 1'h1}, '{6'h29, 1'h1, 16'h1000, 1'h0, 1'h0},
		'{6'h29, 1'h0, 16'h1800, 1'h0, 1'h0}, '{6'h29, 1'h0, 16'h1010, 1'h1, 1'h0},
		'{6'h2D, 1'h0, 16'h1000, 1'h0, 1'h0}};

	svr_bus_if bus ();
	svr_card_port svr_card_port_i (.ref_clk(ref_clk), .srst(srst), .bus(bus.card), .base_sw(base_sw),
		.pos_value(POS), .rate_value(RATE), .ssi_word(SSIW), .ssi_word_vld(ssi_word_vld),
		.ssi_frame_req(ssi_frame_req), .nv_err_evt(nv_err_evt), .init_done(init_done),
		.init_fail(init_fail), .run_led(run_led), .fault_led(fault_led), .cmd_word(cmd_word),
		.par_wr_stb(par_wr_stb), .par_wr_idx(par_wr_idx), .par_wr_data(par_wr_data));
	svr_host_reader svr_host_reader_i (.ref_clk(ref_clk), .srst(srst), .bus(bus.host),
		.rd_start(rd_start), .wr_start(wr_start), .word_mode(word_mode), .am_req(am_req),
		.base_addr(base_addr), .wr_ofs(wr_ofs), .wr_data(wr_data), .busy(busy), .done(done),
		.xfer_ok(xfer_ok), .am_fault(am_fault), .img_data(img_data));
	svr_bus_sva svr_bus_sva_i (.ref_clk(ref_clk), .srst(srst), .am(bus.am), .a(bus.a),
		.as_n(bus.as_n), .ds0_n(bus.ds0_n), .ds1_n(bus.ds1_n), .write_n(bus.write_n),
		.wd(bus.wd), .rd(bus.rd), .dtack_n(bus.dtack_n), .berr_n(bus.berr_n));

	always #5 ref_clk = ~ref_clk;

	// Serial far side hands over one word in the same cycle as each frame request
	always @(posedge ref_clk) begin
		#1;
		ssi_word_vld = ssi_frame_req;
	end

	// Parameter strobes last one cycle, so latch them here
	always @(posedge ref_clk) begin
		if (par_wr_stb) begin
			par_idx_seen <= par_wr_idx;
			par_data_seen <= par_wr_data;
		end
	end

	// Frame requests and answered bytes, counted for the checks after each table read
	always @(posedge ref_clk) begin
		if (ssi_frame_req === 1'h1) frames++;
		if (bus.dtack_n === 1'h0 && ack_prev === 1'h1) acks++;
		ack_prev <= bus.dtack_n;
	end

	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			wrap_up();
		end
	end

	function automatic logic [127:0] img_exp(input logic nv);
		logic [15:0] st;
		st = 16'h0000;
		st[SVR_STAT_RUN_BIT] = 1'h1;
		st[SVR_STAT_NV_ERR_BIT] = nv;
		return {POS, RATE, raw_exp, st, SVR_RSVD_WORD};
	endfunction

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	// One host request, then wait for done and let xfer_ok settle
	task automatic host_op(input logic rd, input logic [10:0] ofs, input logic [7:0] d);
		int n;
		rd_start = rd;
		wr_start = !rd;
		wr_ofs = ofs;
		wr_data = d;
		tick();
		rd_start = 1'h0;
		wr_start = 1'h0;
		`CHK("busy", 1'h1, busy);
		for (n = 0; n < 2000 && done !== 1'h1; n++) tick();
		`CHK("done", 1'h1, done);
		tick();
		`CHK("idle", 1'h0, busy);
	endtask

	task automatic wrap_up();
		$display("mismatches=%0d checks=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		int i;
		repeat (20) @(posedge ref_clk);
		#1;
		srst = 1'h0;
		`CHK("run_led", 1'h0, run_led);
		`CHK("fault_led", 1'h0, fault_led);
		`CHK("cmd_word", SVR_CMD_RESET, cmd_word);
		init_done = 1'h1;
		tick();
		init_done = 1'h0;
		tick();
		`CHK("run_led", 1'h1, run_led);
		// Table of modifiers, widths and windows
		for (i = 0; i < 13; i++) begin
			am_req = rows[i].am;
			word_mode = rows[i].wm;
			base_addr = rows[i].base;
			frames = 0;
			acks = 0;
			host_op(1'h1, 11'h000, 8'h00);
			`CHK("acks", rows[i].ok ? SVR_IMG_BYTES : 0, acks);
			`CHK("frames", (rows[i].ok && rows[i].base == 16'h1000) ? 1 : 0, frames);
			`CHK("xfer_ok", rows[i].ok, xfer_ok);
			`CHK("am_fault", rows[i].amf, am_fault);
			if (rows[i].ok) begin
				`CHK("img", (rows[i].base == 16'h1000) ? img_exp(1'h0) : 128'h0, img_data);
				if (rows[i].base == 16'h1000) raw_exp = SSIW;
			end
		end
		// Memory error set, reported, cleared by a byte write
		am_req = SVR_AM_SHORT_NP;
		word_mode = 1'h0;
		base_addr = 16'h1000;
		nv_err_evt = 1'h1;
		tick();
		nv_err_evt = 1'h0;
		host_op(1'h1, 11'h000, 8'h00);
		`CHK("img_nv", img_exp(1'h1), img_data);
		host_op(1'h0, SVR_OFS_CMD_LO, 8'h01);
		host_op(1'h1, 11'h000, 8'h00);
		`CHK("img_clr", img_exp(1'h0), img_data);
		host_op(1'h0, SVR_OFS_CMD_HI, 8'hA5);
		`CHK("cmd_hi", 8'hA5, cmd_word[15:8]);
		`CHK("cmd_lo", 8'h01, cmd_word[7:0]);
		host_op(1'h0, SVR_OFS_PAR_FIRST + 11'h003, 8'h5A);
		`CHK("par_idx", 4'h3, par_idx_seen);
		`CHK("par_data", 8'h5A, par_data_seen);
		// Failed start-up lights the fault lamp and drops the run lamp
		init_fail = 1'h1;
		tick();
		init_fail = 1'h0;
		tick();
		`CHK("fault_led", 1'h1, fault_led);
		`CHK("run_led", 1'h0, run_led);
		// Mid-run reset clears the lamps and command; the raw word reads absent again
		srst = 1'h1;
		tick();
		tick();
		srst = 1'h0;
		`CHK("fault_rst", 1'h0, fault_led);
		`CHK("cmd_rst", SVR_CMD_RESET, cmd_word);
		`CHK("ok_rst", 1'h0, xfer_ok);
		init_done = 1'h1;
		tick();
		init_done = 1'h0;
		raw_exp = SVR_RAW_ABSENT;
		host_op(1'h1, 11'h000, 8'h00);
		`CHK("img_rst", img_exp(1'h0), img_data);
		// Slot nine window, carrying the word fetched by the previous read
		raw_exp = SSIW;
		base_sw = 5'h09;
		base_addr = 16'h4800;
		host_op(1'h1, 11'h000, 8'h00);
		`CHK("xfer_ok9", 1'h1, xfer_ok);
		`CHK("img9", img_exp(1'h0), img_data);
		wrap_up();
	end
endmodule
`default_nettype wire
